// ===== verilog/evs_indicator_top.sv
// Top of the external vbus indicator select block with its control registers
// Operation
// - Use bit clear: report internal comparator
// - Unqualified, not inverted: report pin directly
// - Unqualified, inverted: report inverted pin
// - Qualified: AND corrected pin with comparator
// - Invert control at interface control bit 5
// - Unqualified select at interface control bit 6
// - Use bit reads cleared after reset
// - Use bit clear: pull-down enabled
// - Use bit set: pull-down disconnected
`timescale 1ns/1ps
module evs_indicator_top
	import evs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic ext_vbus_input_pin,
	input wire logic vbus_valid_comparator,
	input wire logic session_valid_comparator,
	input wire logic session_end_comparator,
	input wire logic rxcmd_taken,
	output logic ext_pulldown_en,
	output logic vbus_valid_out,
	output logic [1:0] rxcmd_vbus_state,
	output logic rxcmd_pending
);
	import evs_pkg::*;

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic [7:0] otg_ctrl;
	logic [7:0] ifc_ctrl;

	// Write decode: plain write, set and clear addresses each
	wire otg_wr = reg_wr && (reg_addr == EVS_OTG_CTRL_ADDR);
	wire otg_set = reg_wr && (reg_addr == EVS_OTG_CTRL_SET);
	wire otg_clr = reg_wr && (reg_addr == EVS_OTG_CTRL_CLR);
	wire ifc_wr = reg_wr && (reg_addr == EVS_IFC_CTRL_ADDR);
	wire ifc_set = reg_wr && (reg_addr == EVS_IFC_CTRL_SET);
	wire ifc_clr = reg_wr && (reg_addr == EVS_IFC_CTRL_CLR);

	wire [7:0] next_otg_ctrl = otg_wr ? reg_wdata : otg_set ? (otg_ctrl | reg_wdata) :
		otg_clr ? (otg_ctrl & ~reg_wdata) : otg_ctrl;
	wire [7:0] next_ifc_ctrl = ifc_wr ? reg_wdata : ifc_set ? (ifc_ctrl | reg_wdata) :
		ifc_clr ? (ifc_ctrl & ~reg_wdata) : ifc_ctrl;

	// Use bit resets cleared so the pin is ignored until the link opts in
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			otg_ctrl <= EVS_OTG_CTRL_RST;
			ifc_ctrl <= EVS_IFC_CTRL_RST;
		end else begin
			otg_ctrl <= next_otg_ctrl;
			ifc_ctrl <= next_ifc_ctrl;
		end
	end

	// ------------------------------------------------------------
	// Field extraction
	// ------------------------------------------------------------
	wire ext_indicator_use = otg_ctrl[EVS_EXT_USE_BIT];
	wire indicator_unqualified_sel = ifc_ctrl[EVS_UNQUAL_BIT];
	wire indicator_invert = ifc_ctrl[EVS_INVERT_BIT];

	// ------------------------------------------------------------
	// Source selection and state encoding
	// ------------------------------------------------------------
	logic vbus_valid_sel;
	logic [1:0] vbus_state;
	logic state_change;

	evs_source_mux u_mux (
		.ext_indicator_use(ext_indicator_use),
		.indicator_unqualified_sel(indicator_unqualified_sel),
		.indicator_invert(indicator_invert),
		.ext_vbus_level(ext_vbus_input_pin),
		.vbus_valid_comparator(vbus_valid_comparator),
		.vbus_valid_sel(vbus_valid_sel)
	);

	evs_vbus_state u_state (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.vbus_valid_sel(vbus_valid_sel),
		.session_valid_comparator(session_valid_comparator),
		.session_end_comparator(session_end_comparator),
		.vbus_state(vbus_state),
		.state_change(state_change)
	);

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Set and clear aliases read back the register itself; unmapped reads are zero
	wire rd_otg = (reg_addr == EVS_OTG_CTRL_ADDR) || (reg_addr == EVS_OTG_CTRL_SET) ||
		(reg_addr == EVS_OTG_CTRL_CLR);
	wire rd_ifc = (reg_addr == EVS_IFC_CTRL_ADDR) || (reg_addr == EVS_IFC_CTRL_SET) ||
		(reg_addr == EVS_IFC_CTRL_CLR);
	wire rd_sts = (reg_addr == EVS_STATUS_ADDR);
	wire [7:0] sts_word = {4'h0, vbus_valid_sel, ext_pulldown_en, vbus_state};
	wire [7:0] rd_word = rd_otg ? otg_ctrl : rd_ifc ? ifc_ctrl : rd_sts ? sts_word : 8'h00;

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_word : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Pending flag: a new change wins over the link taking the previous one
	wire next_pending = state_change | (rxcmd_pending & ~rxcmd_taken);

	// Pull-down held on from reset so an unused pin never floats
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_pulldown_en <= 1'b1;
			vbus_valid_out <= 1'b0;
			rxcmd_vbus_state <= EVS_VBUS_BELOW_SESS_END;
			rxcmd_pending <= 1'b0;
		end else begin
			ext_pulldown_en <= ~next_otg_ctrl[EVS_EXT_USE_BIT];
			vbus_valid_out <= vbus_valid_sel;
			rxcmd_vbus_state <= vbus_state;
			rxcmd_pending <= next_pending;
		end
	end
endmodule

// ===== pkg/evs_pkg.sv
// Package: register map, field positions and reset values for the external vbus indicator select block
package evs_pkg;
	// ------------------------------------------------------------
	// Register offsets (ULPI immediate register addresses)
	// ------------------------------------------------------------
	localparam logic [5:0] EVS_OTG_CTRL_ADDR = 6'h0A;
	localparam logic [5:0] EVS_OTG_CTRL_SET = 6'h0B;
	localparam logic [5:0] EVS_OTG_CTRL_CLR = 6'h0C;
	localparam logic [5:0] EVS_IFC_CTRL_ADDR = 6'h07;
	localparam logic [5:0] EVS_IFC_CTRL_SET = 6'h08;
	localparam logic [5:0] EVS_IFC_CTRL_CLR = 6'h09;
	localparam logic [5:0] EVS_STATUS_ADDR = 6'h3E;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int EVS_EXT_USE_BIT = 7;
	localparam int EVS_UNQUAL_BIT = 6;
	localparam int EVS_INVERT_BIT = 5;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] EVS_OTG_CTRL_RST = 8'h06;
	localparam logic [7:0] EVS_IFC_CTRL_RST = 8'h00;

	// ------------------------------------------------------------
	// Receive command vbus state encoding
	// ------------------------------------------------------------
	localparam logic [1:0] EVS_VBUS_BELOW_SESS_END = 2'h0;
	localparam logic [1:0] EVS_VBUS_SESS_END_TO_VLD = 2'h1;
	localparam logic [1:0] EVS_VBUS_SESS_VLD_TO_VBUS = 2'h2;
	localparam logic [1:0] EVS_VBUS_VALID = 2'h3;
endpackage

// ===== verilog/evs_source_mux.sv
// Source selection for the reported vbus-valid level
`timescale 1ns/1ps
module evs_source_mux (
	input wire logic ext_indicator_use,
	input wire logic indicator_unqualified_sel,
	input wire logic indicator_invert,
	input wire logic ext_vbus_level,
	input wire logic vbus_valid_comparator,
	output logic vbus_valid_sel
);
	// Polarity correction of the external pin
	wire ext_corrected = ext_vbus_level ^ indicator_invert;
	// Qualified form ANDs with the comparator
	wire ext_qualified = ext_corrected & vbus_valid_comparator;
	wire ext_path = indicator_unqualified_sel ? ext_corrected : ext_qualified;
	// Internal comparator unless the external input is in use
	assign vbus_valid_sel = ext_indicator_use ? ext_path : vbus_valid_comparator;
endmodule

// ===== verilog/evs_vbus_state.sv
// Encodes the two-bit receive command vbus state from comparator levels
`timescale 1ns/1ps
module evs_vbus_state
	import evs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic vbus_valid_sel,
	input wire logic session_valid_comparator,
	input wire logic session_end_comparator,
	output logic [1:0] vbus_state,
	output logic state_change
);
	import evs_pkg::*;

	// Priority: valid above session valid above session end
	wire [1:0] next_vbus_state = vbus_valid_sel ? EVS_VBUS_VALID :
		session_valid_comparator ? EVS_VBUS_SESS_VLD_TO_VBUS :
		session_end_comparator ? EVS_VBUS_BELOW_SESS_END : EVS_VBUS_SESS_END_TO_VLD;

	// Register the state and flag a change so the link is told at the next receive command
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			vbus_state <= EVS_VBUS_BELOW_SESS_END;
			state_change <= 1'b0;
		end else begin
			vbus_state <= next_vbus_state;
			state_change <= (next_vbus_state != vbus_state);
		end
	end
endmodule

// ===== sim/evs_indicator_props.sv
// Port-level checker for the indicator select block
`timescale 1ns/1ps
module evs_indicator_props
	import evs_pkg::*;
(
	input wire logic sys_clk, input wire logic arst_n, input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata, input wire logic reg_wr, input wire logic ext_pulldown_en,
	input wire logic vbus_valid_comparator, input wire logic vbus_valid_out, input wire logic [1:0] rxcmd_vbus_state,
	input wire logic rxcmd_pending, input wire logic rxcmd_taken
);
	// ------------------------------------
	// History guard, clocking, sequences
	// ------------------------------------
	logic up;
	wire use_wr = reg_wr && reg_wdata[EVS_EXT_USE_BIT];
	// Low until one edge out of reset, so no check looks back into reset
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) up <= 1'b0;
		else up <= 1'b1;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	sequence s_taken_quiet;
		up && rxcmd_taken ##1 rxcmd_vbus_state == $past(rxcmd_vbus_state);
	endsequence
	// Pull-down low means the use bit is set, so it also tells the source
	a_internal_src: assert property (up && $past(ext_pulldown_en) |-> vbus_valid_out == $past(vbus_valid_comparator))
		else $error("vbus valid not internal");
	a_pd_off: assert property (use_wr && reg_addr == EVS_OTG_CTRL_SET |=> !ext_pulldown_en) else $error("pull-down on");
	a_pd_on: assert property (use_wr && reg_addr == EVS_OTG_CTRL_CLR |=> ext_pulldown_en) else $error("pull-down off");
	a_state_valid: assert property ($past(up) && $past(vbus_valid_out) |-> rxcmd_vbus_state == EVS_VBUS_VALID)
		else $error("state not valid");
	a_state_other: assert property ($past(up) && !$past(vbus_valid_out) |-> rxcmd_vbus_state != EVS_VBUS_VALID)
		else $error("state wrongly valid");
	a_pend_rise: assert property ($past(up) && rxcmd_vbus_state != $past(rxcmd_vbus_state) |-> rxcmd_pending)
		else $error("change not pending");
	a_pend_hold: assert property (up && rxcmd_pending && !rxcmd_taken |=> rxcmd_pending) else $error("pending lost");
	a_pend_clear: assert property (s_taken_quiet |-> !rxcmd_pending) else $error("pending stuck");
endmodule
bind evs_indicator_top evs_indicator_props u_evs_indicator_props (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
	.ext_pulldown_en, .vbus_valid_comparator, .vbus_valid_out, .rxcmd_vbus_state, .rxcmd_pending, .rxcmd_taken);

// ===== sim/evs_link_model.sv
// Link-side model that takes receive commands promptly or after a stall
`timescale 1ns/1ps
module evs_link_model (input wire logic sys_clk, input wire logic arst_n, input wire logic rxcmd_pending,
	input wire logic slow, output logic rxcmd_taken);
	logic [1:0] stall;
	// Slow mode lets pending stand five cycles; vbus state never starts a session here
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			stall <= 2'h0;
			rxcmd_taken <= 1'b0;
		end else begin
			stall <= (rxcmd_pending && !rxcmd_taken) ? stall + 2'h1 : 2'h0;
			rxcmd_taken <= rxcmd_pending && !rxcmd_taken && (!slow || stall == 2'h3);
		end
	end
endmodule

// ===== sim/tb_evs_indicator_top.sv
// Self-checking bench for the indicator select block
`timescale 1ns/1ps
module tb_evs_indicator_top;
	import evs_pkg::*;
	logic sys_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, pin = 0, vc = 0, sc = 0, ec = 0, slow = 0, rd_d = 0;
	logic taken, pend, sel, pd, vv;
	logic [1:0] st, vs;
	logic [5:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, reg_rdata;
	logic [15:0] note;
	logic [31:0] r;
	logic [15:0] exp_q[$];
	int n_mismatch = 0, n_checks = 0, seed = 32497;
	initial forever #2 sys_clk = ~sys_clk;
	evs_indicator_top u_evs_indicator_top (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.ext_vbus_input_pin(pin), .vbus_valid_comparator(vc), .session_valid_comparator(sc),
		.session_end_comparator(ec), .rxcmd_taken(taken), .ext_pulldown_en(pd), .vbus_valid_out(vv),
		.rxcmd_vbus_state(vs), .rxcmd_pending(pend));
	evs_link_model u_evs_link_model (.sys_clk, .arst_n, .rxcmd_pending(pend), .slow, .rxcmd_taken(taken));
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
		n_checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, want, seen);
		end
	endtask
	// One bus cycle; a read queues its answer as {mask, value}
	task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d, input logic [15:0] want);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= d;
		if (!wr) exp_q.push_back(want);
		@(posedge sys_clk);
	endtask
	// Read data stand one cycle only, so they are taken at the edge after the strobe
	always @(posedge sys_clk) begin
		if (rd_d) begin
			note = exp_q.pop_front();
			check(reg_rdata & note[15:8], note[7:0], "reg_rdata");
		end
		rd_d <= reg_rd;
	end
	// Run needs about 1000 cycles
	initial begin
		repeat (3000) @(posedge sys_clk);
		n_mismatch++;
		wrap_up();
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		bus(0, EVS_OTG_CTRL_ADDR, 8'h00, {8'hff, EVS_OTG_CTRL_RST});
		bus(0, EVS_IFC_CTRL_ADDR, 8'h00, {8'hff, EVS_IFC_CTRL_RST});
		bus(0, 6'h20, 8'h00, 16'hff00);
		for (int i = 0; i < 96; i++) begin
			r = $random(seed);
			sel = r[0] ? (r[7] ^ r[2]) & (r[1] | r[6]) : r[6];
			// State priority: vbus valid, then session valid, then session end
			st = sel ? EVS_VBUS_VALID : r[5] ? EVS_VBUS_SESS_VLD_TO_VBUS :
				r[4] ? EVS_VBUS_BELOW_SESS_END : EVS_VBUS_SESS_END_TO_VLD;
			// All eight select settings, qualified mode included
			bus(1, r[0] ? EVS_OTG_CTRL_SET : EVS_OTG_CTRL_CLR, 8'h80, 16'h0000);
			bus(1, EVS_IFC_CTRL_ADDR, {1'b0, r[1], r[2], 5'h00}, 16'h0000);
			{pin, vc, sc, ec, slow} <= r[7:3];
			bus(0, EVS_OTG_CTRL_ADDR, 8'h00, {8'hff, r[0], EVS_OTG_CTRL_RST[6:0]});
			bus(0, EVS_IFC_CTRL_ADDR, 8'h00, {8'hff, 1'b0, r[1], r[2], 5'h00});
			bus(0, EVS_STATUS_ADDR, 8'h00, {8'hff, 4'h0, sel, !r[0], st});
			reg_rd <= 1'b0;
			repeat (5) @(posedge sys_clk);
			// Inputs have been still for several cycles, so the registered outputs have settled
			check({7'h0, vv}, {7'h0, sel}, "vbus_valid_out");
			check({7'h0, pd}, {7'h0, !r[0]}, "ext_pulldown_en");
			check({6'h0, vs}, {6'h0, st}, "rxcmd_vbus_state");
		end
		wrap_up();
	end
endmodule
